// ---- t16ccs_cap_if.sv ----
// Signals between the timer core and one capture unit.
`timescale 1ns/1ps
interface t16ccs_cap_if;
  logic filter_en;
  logic edge_sel;
  logic capture_en;
  logic [15:0] count;
  logic event_pulse;
  logic [15:0] captured;
  modport ctl (output filter_en, output edge_sel, output capture_en, output count,
               input event_pulse, input captured);
  modport cap (input filter_en, input edge_sel, input capture_en, input count,
               output event_pulse, output captured);
endinterface : t16ccs_cap_if

// ---- t16ccs_capture.sv ----
// Capture pin synchroniser, noise filter, edge detector and capture register.
`timescale 1ns/1ps
module t16ccs_capture #(
  parameter int SAMPLES = t16ccs_pkg::FILTER_SAMPLES
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic capture_input_pin_in,
  t16ccs_cap_if.cap port_if
);
  import t16ccs_pkg::*;

  logic [1:0] sync_ff, nxt_sync;
  logic [SAMPLES-1:0] hist_ff, nxt_hist;
  logic filt_ff, nxt_filt;
  logic prev_ff, nxt_prev;
  logic event_ff, nxt_event;
  logic [15:0] captured_ff, nxt_captured;
  logic trig;

  always_comb begin
    nxt_sync = {sync_ff[0], capture_input_pin_in};
    nxt_hist = {hist_ff[SAMPLES-2:0], sync_ff[1]};
    nxt_filt = sync_ff[1];
    if (port_if.filter_en) begin
      // Output moves only once every stored sample agrees.
      if ((&hist_ff) || (~|hist_ff)) begin
        nxt_filt = hist_ff[0];
      end else begin
        nxt_filt = filt_ff;
      end
    end
    nxt_prev = filt_ff;
    trig = port_if.capture_en &&
           (port_if.edge_sel ? (filt_ff && !prev_ff) : (!filt_ff && prev_ff));
    nxt_event = trig;
    nxt_captured = trig ? port_if.count : captured_ff;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_ff <= 2'h0;
      hist_ff <= '0;
      filt_ff <= 1'b0;
      prev_ff <= 1'b0;
      event_ff <= 1'b0;
      captured_ff <= COUNT_RESET;
    end else begin
      sync_ff <= nxt_sync;
      hist_ff <= nxt_hist;
      filt_ff <= nxt_filt;
      prev_ff <= nxt_prev;
      event_ff <= nxt_event;
      captured_ff <= nxt_captured;
    end
  end

  assign port_if.event_pulse = event_ff;
  assign port_if.captured = captured_ff;
endmodule : t16ccs_capture

// ---- t16ccs_checker.sv ----
// Port-level checks for the dual timer block.
`timescale 1ns/1ps
module t16ccs_checker
  import t16ccs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [2:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic [15:0] counter_value_t1_out,
  input wire logic [15:0] capture_register_t3_out,
  input wire logic [1:0] capture_flag_out,
  input wire logic [3:0] waveform_mode_t1_out,
  input wire logic [3:0] waveform_mode_t3_out,
  input wire logic [1:0] timer_tick_out,
  input wire logic [1:0] compare_block_out,
  input wire logic [7:0] temp_high_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence hi_wr_s; io_wr_in && io_addr_in == ADDR_T1_CNT_HI; endsequence
  sequence lo_wr_s; io_wr_in && io_addr_in == ADDR_T1_CNT_LO; endsequence
  // Capture may still be in flight for two cycles after a mode change.
  sequence icr_top_s; (waveform_mode_t3_out[3] && !waveform_mode_t3_out[0]) [*3]; endsequence
  count_commit_a: assert property (hi_wr_s ##1 lo_wr_s |=>
    counter_value_t1_out == {$past(io_wdata_in, 2), $past(io_wdata_in)})
    else $error("counter not committed from latch and low byte");
  block_set_a: assert property (lo_wr_s |=> compare_block_out[0])
    else $error("compare block not raised after counter write");
  block_clear_a: assert property (
    compare_block_out[0] && timer_tick_out[0] && !io_wr_in |=> !compare_block_out[0])
    else $error("compare block outlived the next tick");
  count_hold_a: assert property (
    !timer_tick_out[0] && !(io_wr_in && io_addr_in == ADDR_T1_CNT_LO)
    |=> $stable(counter_value_t1_out)) else $error("counter moved without a tick");
  temp_latch_a: assert property (
    io_rd_in && !io_wr_in && io_addr_in == ADDR_T1_CNT_LO |=>
    {temp_high_out, 8'h00} == ($past(counter_value_t1_out) & 16'hff00))
    else $error("low read did not latch the high byte");
  cap_flag_a: assert property ($changed(capture_register_t3_out) |=> capture_flag_out[1])
    else $error("capture register changed without flag");
  icr_top_a: assert property (icr_top_s |-> !$rose(capture_flag_out[1]))
    else $error("capture while capture register is top");
  wm_upper_a: assert property (io_wr_in && io_addr_in == ADDR_T1_CTRL_B |=>
    waveform_mode_t1_out[3:2] == $past(io_wdata_in[4:3])) else $error("mode bits not stored");
endmodule : t16ccs_checker

bind t16ccs_top t16ccs_checker u_chk (.sys_clk_in, .arst_n_in, .io_addr_in, .io_wr_in,
  .io_rd_in, .io_wdata_in, .counter_value_t1_out, .capture_register_t3_out,
  .capture_flag_out, .waveform_mode_t1_out, .waveform_mode_t3_out, .timer_tick_out,
  .compare_block_out, .temp_high_out);

// ---- t16ccs_pkg.sv ----
// Shared constants and types for the dual 16-bit timer clock select and capture block.
package t16ccs_pkg;
  // I/O locations of the six byte registers.
  localparam logic [2:0] ADDR_T1_CTRL_B = 3'h0;
  localparam logic [2:0] ADDR_T1_CNT_HI = 3'h1;
  localparam logic [2:0] ADDR_T1_CNT_LO = 3'h2;
  localparam logic [2:0] ADDR_T3_CTRL_B = 3'h4;
  localparam logic [2:0] ADDR_T3_CNT_HI = 3'h5;
  localparam logic [2:0] ADDR_T3_CNT_LO = 3'h6;
  // Field positions inside control register B.
  localparam int BIT_FILTER = 7;
  localparam int BIT_EDGE = 6;
  localparam int BIT_WGM_HI = 4;
  localparam int BIT_WGM_LO = 3;
  localparam int BIT_CS_HI = 2;
  // Reset values and the mask of storable bits.
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_WMASK = 8'hdf;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Samples the capture noise filter needs before it changes.
  localparam int FILTER_SAMPLES = 4;
  // Prescaler width and divider exponents.
  localparam int PRESCALE_WIDTH = 10;
  localparam int LOG2_DIV8 = 3;
  localparam int LOG2_DIV16 = 4;
  localparam int LOG2_DIV32 = 5;
  localparam int LOG2_DIV64 = 6;
  localparam int LOG2_DIV256 = 8;
  localparam int LOG2_DIV1024 = 10;
  // Fixed TOP values.
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [3:0] MODE_RESERVED = 4'hd;

  typedef enum logic [2:0] {
    CS_STOP = 3'h0,
    CS_DIV1 = 3'h1,
    CS_DIV8 = 3'h2,
    CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_ALT_A = 3'h6,
    CS_ALT_B = 3'h7
  } t16ccs_clksel_type;
endpackage : t16ccs_pkg

// ---- t16ccs_top.sv ----
// Two 16-bit timers: control register B, clock select, counters and shared high-byte latch.
//
// How it works
// - With filtering on, capture input changes only after four equal samples.
// - Edge select zero captures on falling edge, one on rising edge.
// - A capture copies the counter into the capture register and sets the flag.
// - Modes using the capture register as TOP disable input capture.
// - Control B holds waveform bits three and two, joined with control A's lower bits.
// - Codes 0 to 5: stopped, undivided, divide 8, 64, 256, 1024.
// - Timer one codes 6 and 7 count falling and rising external pin edges.
// - External pin edges count even when the pin drives as an output.
// - Timer three codes 6 and 7 select divide by 16 and 32.
// - Counter bytes move together through one shared 8-bit high-byte latch.
// - A counter write suppresses compare matches on the next timer clock.
// - Mode bits choose counting sequence and TOP; mode 13 is reserved.
`timescale 1ns/1ps
module t16ccs_top (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [2:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  input wire logic [1:0] waveform_mode_lower_t1_in,
  input wire logic [1:0] waveform_mode_lower_t3_in,
  input wire logic [15:0] compare_top_t1_in,
  input wire logic [15:0] compare_top_t3_in,
  input wire logic external_count_pin_in,
  input wire logic [1:0] capture_input_pin_in,
  input wire logic [1:0] capture_flag_clear_in,
  output logic [15:0] counter_value_t1_out,
  output logic [15:0] counter_value_t3_out,
  output logic [15:0] capture_register_t1_out,
  output logic [15:0] capture_register_t3_out,
  output logic [1:0] capture_flag_out,
  output logic [3:0] waveform_mode_t1_out,
  output logic [3:0] waveform_mode_t3_out,
  output logic [1:0] timer_tick_out,
  output logic [1:0] compare_block_out,
  output logic [7:0] temp_high_out
);
  import t16ccs_pkg::*;

  logic [7:0] ctrl_ff [2];
  logic [7:0] nxt_ctrl [2];
  logic [15:0] count_ff [2];
  logic [15:0] nxt_count [2];
  logic [1:0] down_ff, nxt_down;
  logic [1:0] block_ff, nxt_block;
  logic [1:0] flag_ff, nxt_flag;
  logic [7:0] temp_ff, nxt_temp;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [PRESCALE_WIDTH-1:0] pre_ff, nxt_pre;
  logic [1:0] ext_sync_ff, nxt_ext_sync;
  logic ext_prev_ff, nxt_ext_prev;
  logic ext_rise, ext_fall;
  logic [1:0] tick;
  logic [3:0] mode [2];
  logic [15:0] top [2];
  logic [1:0] dual_slope;
  logic [1:0] hi_wr, lo_wr, lo_rd, ctrl_wr;
  logic [1:0] cap_event;
  logic [15:0] cap_value [2];

  t16ccs_cap_if cap_if [2] ();

  function automatic logic div_tick(input logic [PRESCALE_WIDTH-1:0] pre, input int k);
    logic [PRESCALE_WIDTH-1:0] m;
    m = PRESCALE_WIDTH'((1 << k) - 1);
    div_tick = ((pre & m) == m);
  endfunction : div_tick

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cap
      assign cap_if[gi].filter_en = ctrl_ff[gi][BIT_FILTER];
      assign cap_if[gi].edge_sel = ctrl_ff[gi][BIT_EDGE];
      // The capture register is busy as TOP in modes 8, 10, 12 and 14.
      assign cap_if[gi].capture_en = !(mode[gi][3] && !mode[gi][0]);
      assign cap_if[gi].count = count_ff[gi];
      assign cap_event[gi] = cap_if[gi].event_pulse;
      assign cap_value[gi] = cap_if[gi].captured;
      t16ccs_capture #(
        .SAMPLES(FILTER_SAMPLES)
      ) u_capture (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .capture_input_pin_in(capture_input_pin_in[gi]),
        .port_if(cap_if[gi])
      );
    end
  endgenerate

  // Register decode; the same temp latch serves both 16-bit counters of the unit.
  always_comb begin
    ctrl_wr = {io_wr_in && (io_addr_in == ADDR_T3_CTRL_B),
               io_wr_in && (io_addr_in == ADDR_T1_CTRL_B)};
    hi_wr = {io_wr_in && (io_addr_in == ADDR_T3_CNT_HI),
             io_wr_in && (io_addr_in == ADDR_T1_CNT_HI)};
    lo_wr = {io_wr_in && (io_addr_in == ADDR_T3_CNT_LO),
             io_wr_in && (io_addr_in == ADDR_T1_CNT_LO)};
    lo_rd = {io_rd_in && (io_addr_in == ADDR_T3_CNT_LO),
             io_rd_in && (io_addr_in == ADDR_T1_CNT_LO)};
    ext_rise = ext_sync_ff[1] && !ext_prev_ff;
    ext_fall = !ext_sync_ff[1] && ext_prev_ff;
    mode[0] = {ctrl_ff[0][BIT_WGM_HI:BIT_WGM_LO], waveform_mode_lower_t1_in};
    mode[1] = {ctrl_ff[1][BIT_WGM_HI:BIT_WGM_LO], waveform_mode_lower_t3_in};
    nxt_pre = PRESCALE_WIDTH'(pre_ff + 1'b1);
    nxt_ext_sync = {ext_sync_ff[0], external_count_pin_in};
    nxt_ext_prev = ext_sync_ff[1];
    nxt_temp = temp_ff;
    nxt_rdata = BYTE_RESET;
    if (io_rd_in) begin
      case (io_addr_in)
        ADDR_T1_CTRL_B: nxt_rdata = ctrl_ff[0];
        ADDR_T3_CTRL_B: nxt_rdata = ctrl_ff[1];
        ADDR_T1_CNT_LO: nxt_rdata = count_ff[0][7:0];
        ADDR_T3_CNT_LO: nxt_rdata = count_ff[1][7:0];
        ADDR_T1_CNT_HI: nxt_rdata = temp_ff;
        ADDR_T3_CNT_HI: nxt_rdata = temp_ff;
        default: nxt_rdata = BYTE_RESET;
      endcase
    end
    if (lo_rd[0]) begin
      nxt_temp = count_ff[0][15:8];
    end
    if (lo_rd[1]) begin
      nxt_temp = count_ff[1][15:8];
    end
    // A high-byte write in the same cycle as a low-byte read owns the latch.
    if (|hi_wr) begin
      nxt_temp = io_wdata_in;
    end
    for (int t = 0; t < 2; t++) begin
      // Bit five is never stored, so it always reads back as zero.
      nxt_ctrl[t] = ctrl_wr[t] ? (io_wdata_in & CTRL_B_WMASK) : ctrl_ff[t];
      case (t16ccs_clksel_type'(ctrl_ff[t][BIT_CS_HI:0]))
        CS_STOP: tick[t] = 1'b0;
        CS_DIV1: tick[t] = 1'b1;
        CS_DIV8: tick[t] = div_tick(pre_ff, LOG2_DIV8);
        CS_DIV64: tick[t] = div_tick(pre_ff, LOG2_DIV64);
        CS_DIV256: tick[t] = div_tick(pre_ff, LOG2_DIV256);
        CS_DIV1024: tick[t] = div_tick(pre_ff, LOG2_DIV1024);
        CS_ALT_A: tick[t] = (t == 0) ? ext_fall : div_tick(pre_ff, LOG2_DIV16);
        CS_ALT_B: tick[t] = (t == 0) ? ext_rise : div_tick(pre_ff, LOG2_DIV32);
        default: tick[t] = 1'b0;
      endcase
      case (mode[t])
        4'h1, 4'h5: top[t] = TOP_8BIT;
        4'h2, 4'h6: top[t] = TOP_9BIT;
        4'h3, 4'h7: top[t] = TOP_10BIT;
        4'h4, 4'h9, 4'hb, 4'hf: top[t] = (t == 0) ? compare_top_t1_in : compare_top_t3_in;
        4'h8, 4'ha, 4'hc, 4'he: top[t] = cap_value[t];
        default: top[t] = TOP_MAX;
      endcase
      dual_slope[t] = (mode[t] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
      nxt_count[t] = count_ff[t];
      nxt_down[t] = down_ff[t];
      nxt_block[t] = block_ff[t];
      if (lo_wr[t]) begin
        nxt_count[t] = {temp_ff, io_wdata_in};
        nxt_block[t] = 1'b1;
      end else if (tick[t] && (mode[t] != MODE_RESERVED)) begin
        nxt_block[t] = 1'b0;
        if (!dual_slope[t]) begin
          nxt_count[t] = (count_ff[t] >= top[t]) ? COUNT_RESET : 16'(count_ff[t] + 1'b1);
        end else if (!down_ff[t]) begin
          if (count_ff[t] >= top[t]) begin
            nxt_down[t] = 1'b1;
            nxt_count[t] = (top[t] == COUNT_RESET) ? COUNT_RESET : 16'(top[t] - 1'b1);
          end else begin
            nxt_count[t] = 16'(count_ff[t] + 1'b1);
          end
        end else if (count_ff[t] == COUNT_RESET) begin
          nxt_down[t] = 1'b0;
          nxt_count[t] = 16'h0001;
        end else begin
          nxt_count[t] = 16'(count_ff[t] - 1'b1);
        end
      end
      // A capture in the same cycle as a clear still leaves the flag set.
      nxt_flag[t] = cap_event[t] || (flag_ff[t] && !capture_flag_clear_in[t]);
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_ff[0] <= CTRL_B_RESET;
      ctrl_ff[1] <= CTRL_B_RESET;
      count_ff[0] <= COUNT_RESET;
      count_ff[1] <= COUNT_RESET;
      down_ff <= 2'h0;
      block_ff <= 2'h0;
      flag_ff <= 2'h0;
      temp_ff <= BYTE_RESET;
      rdata_ff <= BYTE_RESET;
      pre_ff <= '0;
      ext_sync_ff <= 2'h0;
      ext_prev_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      count_ff <= nxt_count;
      down_ff <= nxt_down;
      block_ff <= nxt_block;
      flag_ff <= nxt_flag;
      temp_ff <= nxt_temp;
      rdata_ff <= nxt_rdata;
      pre_ff <= nxt_pre;
      ext_sync_ff <= nxt_ext_sync;
      ext_prev_ff <= nxt_ext_prev;
    end
  end

  assign io_rdata_out = rdata_ff;
  assign counter_value_t1_out = count_ff[0];
  assign counter_value_t3_out = count_ff[1];
  assign capture_register_t1_out = cap_value[0];
  assign capture_register_t3_out = cap_value[1];
  assign capture_flag_out = flag_ff;
  assign waveform_mode_t1_out = mode[0];
  assign waveform_mode_t3_out = mode[1];
  assign timer_tick_out = tick;
  assign compare_block_out = block_ff;
  assign temp_high_out = temp_ff;
endmodule : t16ccs_top

// ---- tb_top.sv ----
// Self-checking bench for the dual timer block.
`timescale 1ns/1ps
module tb_top;
  import t16ccs_pkg::*;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [2:0] io_addr_in = 3'h0;
  logic io_wr_in = 1'b0;
  logic io_rd_in = 1'b0;
  logic [7:0] io_wdata_in = 8'h00;
  logic [1:0] wl1 = 2'h0;
  logic [1:0] wl3 = 2'h0;
  logic external_count_pin_in = 1'b0;
  logic [1:0] capture_input_pin_in = 2'h0;
  logic [1:0] capture_flag_clear_in = 2'h0;
  logic [7:0] io_rdata_out, temp_high_out;
  logic [15:0] cnt1, cnt3, cap1, capture_register_t3_out;
  logic [1:0] capture_flag_out, timer_tick_out, compare_block_out;
  logic [3:0] wm1, wm3;
  int n_fail = 0;
  int samples_checked = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  t16ccs_top dut (.sys_clk_in, .arst_n_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in,
    .io_rdata_out, .waveform_mode_lower_t1_in(wl1), .waveform_mode_lower_t3_in(wl3),
    .compare_top_t1_in(16'h0000), .compare_top_t3_in(16'h0000), .external_count_pin_in,
    .capture_input_pin_in, .capture_flag_clear_in, .counter_value_t1_out(cnt1),
    .counter_value_t3_out(cnt3), .capture_register_t1_out(cap1), .capture_register_t3_out,
    .capture_flag_out, .waveform_mode_t1_out(wm1), .waveform_mode_t3_out(wm3),
    .timer_tick_out, .compare_block_out, .temp_high_out);
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = 1'b1;
    cyc(1);
    io_wr_in = 1'b0;
    cyc(1);
  endtask : wr_reg
  // High byte and low byte go out on consecutive cycles, as software would do it.
  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    io_addr_in = a;
    io_wdata_in = v[15:8];
    io_wr_in = 1'b1;
    cyc(1);
    io_addr_in = a + 3'h1;
    io_wdata_in = v[7:0];
    cyc(1);
    io_wr_in = 1'b0;
    cyc(1);
  endtask : wr16
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    io_addr_in = a;
    io_rd_in = 1'b1;
    cyc(1);
    io_rd_in = 1'b0;
    chk(16'(io_rdata_out), 16'(e));
    cyc(1);
  endtask : rd_chk
  task automatic t_regs;
    for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00);
    wl1 = 2'b10;
    for (int j = 0; j < 8; j += 4) begin
      wr_reg(3'(j), 8'hdf);
      rd_chk(3'(j), 8'hdf);
      if (j == 0) chk(16'(wm1), 16'h000e);
      else chk(16'(wm3), 16'h000c);
      wr_reg(3'(j), 8'h00);
    end
    wl1 = 2'b00;
    wr_reg(3'h3, 8'hff);
    rd_chk(3'h3, 8'h00);
  endtask : t_regs
  task automatic t_count16;
    wr16(ADDR_T1_CNT_HI, 16'h1234);
    chk(cnt1, 16'h1234);
    chk(16'(compare_block_out[0]), 16'h0001);
    rd_chk(ADDR_T1_CNT_LO, 8'h34);
    chk(16'(temp_high_out), 16'h0012);
    wr_reg(ADDR_T3_CNT_HI, 8'hab);
    rd_chk(ADDR_T1_CNT_HI, 8'hab);
    wr_reg(ADDR_T3_CNT_LO, 8'hcd);
    chk(cnt3, 16'habcd);
    chk(16'(compare_block_out[1]), 16'h0001);
  endtask : t_count16
  task automatic t_ext;
    logic [15:0] c0;
    for (int m = 6; m < 8; m++) begin
      wr_reg(ADDR_T1_CTRL_B, 8'(m));
      c0 = cnt1;
      for (int p = 0; p < 3; p++) begin
        external_count_pin_in = 1'b1;
        cyc(8);
        chk(cnt1 - c0, 16'(p + m - 6));
        external_count_pin_in = 1'b0;
        cyc(8);
      end
      chk(cnt1 - c0, 16'h0003);
    end
    // Reserved mode 13 must hold the counter even with a running clock.
    wl1 = 2'b01;
    wr_reg(ADDR_T1_CTRL_B, 8'h19);
    c0 = cnt1;
    cyc(8);
    chk(cnt1, c0);
    wr_reg(ADDR_T1_CTRL_B, 8'h00);
    wl1 = 2'b00;
  endtask : t_ext
  task automatic cap_step(input logic [7:0] ctl, input logic lvl, input int hold,
                          input logic exp);
    logic seen;
    seen = 1'b0;
    wr_reg(ADDR_T3_CTRL_B, ctl);
    capture_input_pin_in[1] = lvl;
    for (int k = 0; k < 24; k++) begin
      if (k == hold) capture_input_pin_in[1] = ~lvl;
      if (capture_flag_out[1] === 1'b1) seen = 1'b1;
      cyc(1);
    end
    chk(16'(seen), 16'(exp));
    if (exp) chk(capture_register_t3_out, 16'h5a3c);
    capture_flag_clear_in[1] = 1'b1;
    cyc(1);
    capture_flag_clear_in[1] = 1'b0;
  endtask : cap_step
  task automatic t_capture;
    wr16(ADDR_T3_CNT_HI, 16'h5a3c);
    cap_step(8'h40, 1'b1, 99, 1'b1);
    cap_step(8'h40, 1'b0, 99, 1'b0);
    cap_step(8'h00, 1'b1, 99, 1'b0);
    cap_step(8'h00, 1'b0, 99, 1'b1);
    cap_step(8'hc0, 1'b1, 2, 1'b0);
    cap_step(8'hc0, 1'b1, 99, 1'b1);
    cap_step(8'h18, 1'b0, 99, 1'b0);
    wl3 = 2'b10;
    cap_step(8'h50, 1'b1, 99, 1'b0);
    wl3 = 2'b00;
    wr_reg(ADDR_T3_CTRL_B, 8'h00);
    wr16(ADDR_T1_CNT_HI, 16'h0c3a);
    wr_reg(ADDR_T1_CTRL_B, 8'h40);
    capture_input_pin_in[0] = 1'b1;
    cyc(8);
    chk(16'(capture_flag_out[0]), 16'h0001);
    chk(cap1, 16'h0c3a);
    capture_flag_clear_in[0] = 1'b1;
    cyc(1);
    capture_flag_clear_in[0] = 1'b0;
    chk(16'(capture_flag_out[0]), 16'h0000);
    capture_input_pin_in[0] = 1'b0;
    wr_reg(ADDR_T1_CTRL_B, 8'h00);
  endtask : t_capture
  // A window of 2048 cycles holds a whole number of periods of every divider.
  task automatic clk_chk(input logic [2:0] a, input int i, input int c, input int div);
    int n;
    logic [15:0] c0;
    n = 0;
    wr_reg(a, 8'(c));
    c0 = i ? cnt3 : cnt1;
    for (int k = 0; k < 2048; k++) begin
      if (timer_tick_out[i] === 1'b1) n++;
      cyc(1);
    end
    chk(16'(n), div ? 16'(2048 / div) : 16'h0000);
    chk((i ? cnt3 : cnt1) - c0, 16'(n));
    wr_reg(a, 8'h00);
  endtask : clk_chk
  task automatic t_clksel;
    int divs [8] = '{0, 1, 8, 64, 256, 1024, 16, 32};
    for (int c = 0; c < 8; c++) begin
      if (c < 6) clk_chk(ADDR_T1_CTRL_B, 0, c, divs[c]);
      clk_chk(ADDR_T3_CTRL_B, 1, c, divs[c]);
    end
  endtask : t_clksel
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    cyc(5);
    arst_n_in = 1'b1;
    t_regs;
    $display("register test done");
    t_count16;
    $display("counter access test done");
    t_ext;
    $display("external clock test done");
    t_capture;
    $display("capture test done");
    t_clksel;
    $display("clock select test done");
    tally_and_finish;
  end
  initial begin
    cyc(60000);
    n_fail++;
    $display("Error at %0t: run limit reached", $time);
    tally_and_finish;
  end
endmodule : tb_top
